/* hdl/fanout_map.svh */
`ifndef FANOUT_MAP_SVH
`define FANOUT_MAP_SVH

// ----------------------------------------------------------------
// Serial slave address and register indices
// ----------------------------------------------------------------
`define SLAVE_ADDR      7'h6e
`define IDX_CTRL0       8'h00
`define IDX_CTRL1       8'h01
`define IDX_CTRL2       8'h02
`define IDX_IDENT       8'h03

// ----------------------------------------------------------------
// Reset values and writable bit masks
// ----------------------------------------------------------------
`define CTRL0_RST       8'h07
`define CTRL1_RST       8'h66
`define CTRL2_RST       8'h00
`define CTRL0_WMASK     8'hc7
`define CTRL1_WMASK     8'h66
`define CTRL2_WMASK     8'h66

// ----------------------------------------------------------------
// Field positions in control byte 0
// ----------------------------------------------------------------
`define BIT_NORMAL_FREQ 0
`define BIT_PLL_PATH    1
`define BIT_LOW_BW      2
`define BIT_HALT_FLOAT  6
`define BIT_PD_FLOAT    7

// ----------------------------------------------------------------
// Per-pair bit positions in control bytes 1 and 2
// ----------------------------------------------------------------
`define PAIR0_BIT       3'h1
`define PAIR1_BIT       3'h2
`define PAIR2_BIT       3'h5
`define PAIR3_BIT       3'h6

// ----------------------------------------------------------------
// Synchroniser reset pattern and bit counts
// ----------------------------------------------------------------
`define PIN_SYNC_RST    10'h3ff
`define BITS_PER_BYTE   4'h8

`endif

/* hdl/fanout_pkg.sv */
package fanout_pkg;

  // Serial slave sequencer states
  typedef enum logic [2:0] {
    SL_IDLE,
    SL_ADDR,
    SL_INDEX,
    SL_COUNT,
    SL_WDATA,
    SL_RDATA,
    SL_DONE
  } slave_state_t;

endpackage

/* hdl/regbank_if.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Link between serial slave and control byte store
// ----------------------------------------------------------------
interface regbank_if;
  logic       wr_en;
  logic [7:0] idx;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;

  modport host  (output wr_en, idx, wr_data, input rd_data, ctrl0, ctrl1, ctrl2);
  modport store (input wr_en, idx, wr_data, output rd_data, ctrl0, ctrl1, ctrl2);
endinterface

`default_nettype wire

/* hdl/control_bytes.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fanout_map.svh"

// ----------------------------------------------------------------
// Control byte store with registered read port
// ----------------------------------------------------------------
module control_bytes #(
  parameter logic [7:0] IDENT_CODE = 8'h5a  // Arbitrary identity value
) (
  input wire logic clk,        // System clock
  input wire logic nrst,       // Async reset, active low
  regbank_if.store bus         // Access from the serial slave
);

  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] rd_data;

  // Masked write data, reserved bits stay zero
  wire  [7:0] wd0 = bus.wr_data & `CTRL0_WMASK;  // R18
  wire  [7:0] wd1 = bus.wr_data & `CTRL1_WMASK;
  wire  [7:0] wd2 = bus.wr_data & `CTRL2_WMASK;

  // Read selection, unmapped indices read zero
  wire  [7:0] rd_sel = (bus.idx == `IDX_CTRL0) ? ctrl0 :
                       (bus.idx == `IDX_CTRL1) ? ctrl1 :
                       (bus.idx == `IDX_CTRL2) ? ctrl2 :
                       (bus.idx == `IDX_IDENT) ? IDENT_CODE : 8'h00;

  // Stored bytes, power-up defaults on reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl0   <= `CTRL0_RST;  // R12 R13 R14 R15
      ctrl1   <= `CTRL1_RST;
      ctrl2   <= `CTRL2_RST;  // R16
      rd_data <= 8'h00;
    end else begin
      if (bus.wr_en && bus.idx == `IDX_CTRL0) ctrl0 <= wd0;
      if (bus.wr_en && bus.idx == `IDX_CTRL1) ctrl1 <= wd1;
      if (bus.wr_en && bus.idx == `IDX_CTRL2) ctrl2 <= wd2;
      rd_data <= rd_sel;
    end
  end

  assign bus.ctrl0   = ctrl0;
  assign bus.ctrl1   = ctrl1;
  assign bus.ctrl2   = ctrl2;
  assign bus.rd_data = rd_data;

endmodule

`default_nettype wire

/* hdl/clock_fanout_output_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fanout_map.svh"

// How it works
// R1: Reference clock copied to four output pairs, through PLL path or around it.
// R2: Asserted clock-stop or power-down stops outputs.
// R3: Host releases both serial lines while power-down is asserted.
// R4: Polarity select high inverts both gates, clock-stop and power-down.
// R5: Gate zero enables pair zero, gate three pair three, active high.
// R6: A pin selects PLL path or direct fan-out.
// R7: A pin selects PLL bandwidth.
// R8: Serial slave only, indexed block write and read.
// R9: Answers only address 1101110, last bit 0 write, 1 read.
// R10: Start, address, index, count, N data bytes, each acknowledged, stop.
// R11: Host never sends zero byte count on a write.
// R12: Byte 0 bit 0: 0 divides by two, 1 normal; resets 1.
// R13: Byte 0 bit 1: 0 fan-out, 1 PLL; resets 1.
// R14: Byte 0 bit 2: 0 high bandwidth, 1 low; resets 1.
// R15: Byte 0 bits 6,7: stopped outputs driven or floated; reset 0.
// R16: Byte 2 mask bits let each pair stop on clock-stop; reset 0.
// R17: Register index steps by one after each data byte.
// R18: Reserved bits 3 to 5 of byte 0 ignore writes.
module clock_fanout_output_control (
  input  wire logic       clk,                // System clock, 10 MHz
  input  wire logic       nrst,               // Async reset, active low
  input  wire logic       scl_in,             // Serial clock pin
  input  wire logic       sda_in,             // Serial data pin level
  output logic            sda_out,            // Serial data drive value
  output logic            sda_oe,             // Serial data drive enable
  input  wire logic       ref_clk_in,         // Reference clock
  input  wire logic       gate_polarity_sel,  // Inverts gate pins when high
  input  wire logic       clock_halt_n,       // Clock stop, active low
  input  wire logic       power_off_n,        // Power down, active low
  input  wire logic       oe0_in,             // Gate for pair 0
  input  wire logic       oe3_in,             // Gate for pair 3
  input  wire logic       path_pll_sel,       // High selects PLL path
  input  wire logic       loop_bandwidth_sel, // High selects low bandwidth
  output logic [3:0]      out_clk,            // Output pair clocks
  output logic [3:0]      out_float,          // Output pair floated
  output logic            div_half,           // Outputs divided by two
  output logic            pll_path,           // PLL path in use
  output logic            low_bw              // Low PLL bandwidth in use
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic       scl_d;
  logic       sda_d;
  logic       ref_d;
  wire  [9:0] raw_pins = {scl_in, sda_in, ref_clk_in, gate_polarity_sel, clock_halt_n,
                          power_off_n, oe0_in, oe3_in, path_pll_sel, loop_bandwidth_sel};

  // Two flops on every pin, then one more for edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= `PIN_SYNC_RST;
      sync2 <= `PIN_SYNC_RST;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      ref_d <= 1'b1;
    end else begin
      sync1 <= raw_pins;
      sync2 <= sync1;
      scl_d <= sync2[9];
      sda_d <= sync2[8];
      ref_d <= sync2[7];
    end
  end

  wire scl_s   = sync2[9];
  wire sda_s   = sync2[8];
  wire ref_s   = sync2[7];
  wire pol     = sync2[6];
  wire halt_act = ~(sync2[5] ^ pol);  // R4
  wire pd_act   = ~(sync2[4] ^ pol);  // R4
  wire oe0_act  = sync2[3] ^ pol;     // R4
  wire oe3_act  = sync2[2] ^ pol;     // R4
  wire path_pin = sync2[1];
  wire bw_pin   = sync2[0];

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire sda_start = scl_s & scl_d & sda_d & ~sda_s;
  wire sda_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Control byte store
  // ----------------------------------------------------------------
  regbank_if rb ();

  control_bytes u_bytes (
    .clk  (clk),
    .nrst (nrst),
    .bus  (rb.store)
  );

  // ----------------------------------------------------------------
  // Serial slave sequencer
  // ----------------------------------------------------------------
  fanout_pkg::slave_state_t st;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] index;
  logic [7:0] count;
  logic       rw;
  logic       in_ack;
  logic       wr_pulse;
  logic [7:0] wr_byte;

  wire byte_done = scl_fall & ~in_ack & (bitcnt == `BITS_PER_BYTE);
  wire ack_end   = scl_fall & in_ack;
  wire addr_hit  = (shreg[7:1] == `SLAVE_ADDR);                   // R9
  wire tx_bit    = (st == fanout_pkg::SL_RDATA) & ~in_ack & (bitcnt != 4'h0)
                   & (bitcnt != `BITS_PER_BYTE) & scl_fall;
  wire last_byte = (count == 8'h01);

  assign rb.wr_en   = wr_pulse;
  assign rb.idx     = index;
  assign rb.wr_data = wr_byte;

  // Byte framing, acknowledge and data movement
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st       <= fanout_pkg::SL_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      index    <= 8'h00;
      count    <= 8'h00;
      rw       <= 1'b0;
      in_ack   <= 1'b0;
      sda_oe   <= 1'b0;
      sda_out  <= 1'b0;
      wr_pulse <= 1'b0;
      wr_byte  <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      sda_out  <= 1'b0;
      // Step index and remaining count once a written byte lands
      if (wr_pulse) begin
        index <= index + 8'h01;         // R17
        count <= count - 8'h01;
      end
      if (pd_act || sda_stop) begin
        st     <= fanout_pkg::SL_IDLE;  // R3
        sda_oe <= 1'b0;
        in_ack <= 1'b0;
      end else if (sda_start) begin
        st     <= fanout_pkg::SL_ADDR;  // R10
        bitcnt <= 4'h0;
        in_ack <= 1'b0;
        sda_oe <= 1'b0;
      end else if (scl_rise && !in_ack && bitcnt != `BITS_PER_BYTE) begin
        shreg  <= {shreg[6:0], sda_s};
        bitcnt <= bitcnt + 4'h1;
      end else if (scl_rise && in_ack && !sda_oe && st == fanout_pkg::SL_RDATA) begin
        index <= index + 8'h01;         // R17
        count <= count - 8'h01;
        if (sda_s || last_byte) st <= fanout_pkg::SL_DONE;
      end else if (byte_done) begin
        in_ack <= 1'b1;
        bitcnt <= 4'h0;
        sda_oe <= (st != fanout_pkg::SL_IDLE) && (st != fanout_pkg::SL_DONE)
                  && (st != fanout_pkg::SL_RDATA) && (st != fanout_pkg::SL_ADDR || addr_hit);
        unique case (st)
          fanout_pkg::SL_ADDR: begin
            rw <= shreg[0];             // R9
            st <= addr_hit ? fanout_pkg::SL_INDEX : fanout_pkg::SL_IDLE;
          end
          fanout_pkg::SL_INDEX: begin
            index <= shreg;             // R8
            st    <= fanout_pkg::SL_COUNT;
          end
          fanout_pkg::SL_COUNT: begin
            count <= shreg;
            if (shreg == 8'h00) st <= fanout_pkg::SL_DONE;
            else st <= rw ? fanout_pkg::SL_RDATA : fanout_pkg::SL_WDATA;
          end
          fanout_pkg::SL_WDATA: begin
            wr_pulse <= 1'b1;
            wr_byte  <= shreg;
            if (last_byte) st <= fanout_pkg::SL_DONE;
          end
          fanout_pkg::SL_IDLE, fanout_pkg::SL_RDATA, fanout_pkg::SL_DONE: begin
          end
        endcase
      end else if (ack_end) begin
        in_ack <= 1'b0;
        if (st == fanout_pkg::SL_RDATA) begin
          shreg  <= rb.rd_data;
          sda_oe <= ~rb.rd_data[7];
          bitcnt <= 4'h0;
        end else begin
          sda_oe <= 1'b0;
        end
      end else if (tx_bit) begin
        sda_oe <= ~shreg[7];
      end else if (scl_fall && st == fanout_pkg::SL_RDATA && bitcnt == 4'h0) begin
        sda_oe <= sda_oe;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output gating
  // ----------------------------------------------------------------
  function automatic logic [2:0] pair_bit(input logic [1:0] p);
    unique case (p)
      2'h0:    pair_bit = `PAIR0_BIT;
      2'h1:    pair_bit = `PAIR1_BIT;
      2'h2:    pair_bit = `PAIR2_BIT;
      default: pair_bit = `PAIR3_BIT;
    endcase
  endfunction

  logic       half;
  wire  [3:0] pin_gate = {oe3_act, 1'b1, 1'b1, oe0_act};                     // R5
  wire  [3:0] reg_gate;
  wire  [3:0] halt_mask;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_pair
    assign reg_gate[g]  = rb.ctrl1[pair_bit(2'(g))];
    assign halt_mask[g] = rb.ctrl2[pair_bit(2'(g))];
  end
  wire  [3:0] halt_stop = {4{halt_act}} & halt_mask;                         // R16
  wire  [3:0] stop      = {4{pd_act}} | halt_stop | ~(pin_gate & reg_gate);  // R2
  wire  [3:0] flt       = pd_act ? {4{rb.ctrl0[`BIT_PD_FLOAT]}}              // R15
                                 : halt_stop & {4{rb.ctrl0[`BIT_HALT_FLOAT]}};
  wire        base_clk  = rb.ctrl0[`BIT_NORMAL_FREQ] ? ref_s : half;         // R12

  // Divider, pair clocks and mode outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half      <= 1'b0;
      out_clk   <= 4'h0;
      out_float <= 4'h0;
      div_half  <= 1'b0;
      pll_path  <= 1'b0;
      low_bw    <= 1'b0;
    end else begin
      if (ref_s && !ref_d) half <= ~half;
      out_clk   <= {4{base_clk}} & ~stop;                                    // R1
      out_float <= flt;
      div_half  <= ~rb.ctrl0[`BIT_NORMAL_FREQ];
      pll_path  <= path_pin & rb.ctrl0[`BIT_PLL_PATH];                       // R6 R13
      low_bw    <= bw_pin & rb.ctrl0[`BIT_LOW_BW];                           // R7 R14
    end
  end

endmodule

`default_nettype wire

/* test/fanout_chk.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------
// Port checker
// ----------
module fanout_chk (
  input wire logic       clk,                // Clock
  input wire logic       nrst,               // Reset
  input wire logic       scl_in,             // Serial clock
  input wire logic       sda_out,            // Data value
  input wire logic       sda_oe,             // Data enable
  input wire logic       gate_polarity_sel,  // Polarity
  input wire logic       clock_halt_n,       // Clock stop
  input wire logic       power_off_n,        // Power down
  input wire logic       oe0_in,             // Gate 0
  input wire logic       oe3_in,             // Gate 3
  input wire logic       path_pll_sel,       // Path pin
  input wire logic       loop_bandwidth_sel, // Bandwidth pin
  input wire logic [3:0] out_clk,            // Pair clocks
  input wire logic [3:0] out_float,          // Pair floats
  input wire logic       div_half,           // Half rate
  input wire logic       pll_path,           // Path in use
  input wire logic       low_bw              // Bandwidth in use
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Stop requests after polarity
  wire logic pd_on   = power_off_n == gate_polarity_sel;
  wire logic halt_on = clock_halt_n == gate_polarity_sel;

  chk_od_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  chk_ack_clock_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved while clock high");
  chk_pd_stops_all: assert property (pd_on [*6] |-> out_clk == 4'h0 && !sda_oe)
    else $error("outputs alive in power down");
  chk_run_no_float: assert property ((!pd_on && !halt_on) [*6] |-> out_float == 4'h0)
    else $error("float without stop");
  chk_gate0_off: assert property ((oe0_in == gate_polarity_sel) [*6] |-> !out_clk[0])
    else $error("pair 0 runs while gated");
  chk_gate3_off: assert property ((oe3_in == gate_polarity_sel) [*6] |-> !out_clk[3])
    else $error("pair 3 runs while gated");
  chk_path_pin: assert property (!path_pll_sel [*5] |-> !pll_path)
    else $error("path pin ignored");
  chk_bw_pin: assert property (!loop_bandwidth_sel [*5] |-> !low_bw)
    else $error("bandwidth pin ignored");
  chk_reset_state: assert property ($rose(nrst) |-> ##4 !div_half && out_float == 4'h0)
    else $error("wrong power-up state");
endmodule

bind clock_fanout_output_control fanout_chk u_fanout_chk (
  .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .gate_polarity_sel(gate_polarity_sel), .clock_halt_n(clock_halt_n),
  .power_off_n(power_off_n), .oe0_in(oe0_in), .oe3_in(oe3_in),
  .path_pll_sel(path_pll_sel), .loop_bandwidth_sel(loop_bandwidth_sel),
  .out_clk(out_clk), .out_float(out_float), .div_half(div_half),
  .pll_path(pll_path), .low_bw(low_bw)
);

`default_nettype wire

/* test/smbus_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------
// Serial host and reference source
// ----------
module smbus_host_model (
  input  wire logic clk,     // System clock
  input  wire logic sda,     // Resolved data line
  output var logic  scl,     // Clock line
  output var logic  sda_low, // Host pulls data low
  output var logic  ref_clk  // Reference clock
);
  // Both lines released, reference runs free
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    ref_clk = 1'b0;
  end
  always #400 ref_clk = ~ref_clk;
  // Phase spacing well above the sync depth
  task automatic hp;
    repeat (10) @(posedge clk);
    #1;
  endtask
  // Data falls while clock high
  task automatic host_start;
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask
  // Data rises while clock high, lines left released
  task automatic host_stop;
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask
  // Byte MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    logic [8:0] sh;
    logic [8:0] qs;
    sh = {d, ack_in};
    for (int i = 0; i < 9; i++) begin
      sda_low = !sh[8];
      hp();
      scl = 1'b1;
      hp();
      qs = {qs[7:0], sda};
      scl = 1'b0;
      hp();
      sh = sh << 1;
    end
    q = qs[8:1];
    ack = qs[0];
  endtask
endmodule

`default_nettype wire

/* test/clock_fanout_output_control_test.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------
// Bench top
// ----------
module clock_fanout_output_control_test;
  typedef struct {string nm; logic [7:0] v;} note_t;
  logic clk = 1'b0, nrst = 1'b0, pol = 1'b0, halt_n = 1'b1, pd_n = 1'b1;
  logic oe0 = 1'b1, oe3 = 1'b1, psel = 1'b1, bsel = 1'b1;
  wire logic scl, sda, sda_low, sda_out, sda_oe, ref_clk, div_half, pll_path, low_bw;
  wire logic [3:0] out_clk, out_float;
  logic [31:0] lfsr = 32'h00017674;
  note_t exp_q[$];
  logic [7:0] obs_q[$];
  int fails = 0, n_compared = 0;

  always #50 clk = ~clk;
  // Open-drain data line with pull-up
  assign sda = !(sda_low || (sda_oe && !sda_out));

  clock_fanout_output_control u_clock_fanout_output_control (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .ref_clk_in(ref_clk), .gate_polarity_sel(pol),
    .clock_halt_n(halt_n), .power_off_n(pd_n), .oe0_in(oe0), .oe3_in(oe3),
    .path_pll_sel(psel), .loop_bandwidth_sel(bsel), .out_clk(out_clk),
    .out_float(out_float), .div_half(div_half), .pll_path(pll_path), .low_bw(low_bw));
  smbus_host_model u_smbus_host_model (
    .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low), .ref_clk(ref_clk));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Note an expectation with the value seen
  task automatic note(input string nm, input logic [7:0] e, input logic [7:0] s);
    exp_q.push_back('{nm, e});
    obs_q.push_back(s);
  endtask
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Watcher takes the oldest note per result
  always @(negedge clk) begin
    note_t n;
    while (obs_q.size() > 0) begin
      n = exp_q.pop_front();
      check(n.nm, n.v, obs_q.pop_front());
    end
  end
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Pin order: polarity, stop, power, gate 0, gate 3, path, bandwidth
  task automatic pins(input logic [6:0] v, input int cyc);
    @(posedge clk);
    #1;
    {pol, halt_n, pd_n, oe0, oe3, psel, bsel} = v;
    repeat (cyc) @(posedge clk);
  endtask
  task automatic watch(output logic [7:0] hi);
    hi = 8'h00;
    repeat (40) @(negedge clk) hi[3:0] |= out_clk;
  endtask
  // Indexed block transfer, count never zero
  task automatic blk(input logic [7:0] a, input logic [7:0] idx, input int n,
                     input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    logic [7:0] q;
    logic k_ack;
    rd = 32'h0;
    u_smbus_host_model.host_start();
    u_smbus_host_model.xfer(a, 1'b1, q, k_ack);
    ok = !k_ack;
    if (ok) begin
      u_smbus_host_model.xfer(idx, 1'b1, q, k_ack);
      u_smbus_host_model.xfer(n[7:0], 1'b1, q, k_ack);
      for (int k = 0; k < n; k++) begin
        u_smbus_host_model.xfer(a[0] ? 8'hff : wd[31-8*k -: 8], a[0] ? (k == n - 1) : 1'b1,
                                q, k_ack);
        rd[31-8*k -: 8] = q;
      end
    end
    u_smbus_host_model.host_stop();
  endtask
  // Hang guard
  initial begin
    #5000000;
    fails++;
    end_of_test();
  end
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic ok;
    logic [7:0] hi, r;
    pins(7'h3f, 7);
    #1;
    nrst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    note("outs", 8'h03, {5'h0, div_half, pll_path, low_bw});
    blk(8'hdd, 8'h00, 3, 32'h0, rd, ok);
    note("rd_ack", 8'h01, {7'h0, ok});
    note("byte0", 8'h07, rd[31:24]);
    note("byte1", 8'h66, rd[23:16]);
    note("byte2", 8'h00, rd[15:8]);
    blk(8'hde, 8'h00, 1, 32'h0, rd, ok);
    note("bad_addr_ack", 8'h00, {7'h0, ok});
    $display("test registers done");
    blk(8'hdc, 8'h00, 3, 32'hf8666600, rd, ok);
    note("wr_ack", 8'h01, {7'h0, ok});
    blk(8'hdd, 8'h00, 3, 32'h0, rd, ok);
    note("byte0", 8'hc0, rd[31:24]);
    note("byte2", 8'h66, rd[15:8]);
    note("outs", 8'h04, {5'h0, div_half, pll_path, low_bw});
    $display("test block write done");
    pins(7'h1f, 8);
    note("halt_clk", 8'h00, {4'h0, out_clk});
    note("halt_float", 8'h0f, {4'h0, out_float});
    pins(7'h31, 8);
    watch(hi);
    note("gated", 8'h06, hi);
    note("gate_float", 8'h00, {4'h0, out_float});
    pins(7'h40, 8);
    watch(hi);
    note("inverted", 8'h0f, hi);
    pins(7'h50, 8);
    note("pd_float", 8'h0f, {4'h0, out_float});
    pins(7'h3f, 8);
    $display("test pins done");
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      r = lfsr[7:0];
      pins({5'h0f, lfsr[9:8]}, 8);
      blk(8'hdc, 8'h00, 1, {r, 24'h0}, rd, ok);
      blk(8'hdd, 8'h00, 1, 32'h0, rd, ok);
      note("rnd_byte0", r & 8'hc7, rd[31:24]);
      note("rnd_outs", {5'h0, !r[0], r[1] & lfsr[9], r[2] & lfsr[8]},
           {5'h0, div_half, pll_path, low_bw});
    end
    $display("test random done");
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule

`default_nettype wire
